// *** exec_pkg.sv ***
// Purpose: shared constants and types for the move/or execution datapath
// Assumes: 12-bit instruction words, 8-bit data, 32 file locations
// Notes:   opcode patterns follow the baseline 12-bit encoding
`default_nettype none
package exec_pkg;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          DATA_W      = 8;
  localparam int          FADDR_W     = 5;
  localparam int          NUM_FILES   = 32;
  localparam logic [7:0]  W_RST       = 8'h00;
  localparam logic [7:0]  OPTION_RST  = 8'hFF;
  localparam logic [7:0]  FILE_RST    = 8'h00;
  localparam int          DEST_BIT    = 5;
  localparam int          FADDR_LSB   = 0;

  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [11:0] OP_NOP          = 12'h000;
  localparam logic [11:0] OP_OPTION       = 12'h002;
  localparam logic [5:0]  OP_W_TO_FILE_HI = 6'h00;  // 0000_001f_ffff, bit5 set
  localparam logic [5:0]  OP_IOR_HI       = 6'h04;  // 0001_00df_ffff
  localparam logic [5:0]  OP_MOVE_FILE_HI = 6'h08;  // 0010_00df_ffff
  localparam logic [3:0]  OP_LITERAL_HI   = 4'hC;   // 1100_kkkk_kkkk

  typedef enum logic [2:0] {
    OPK_NONE, OPK_OR, OPK_W_TO_FILE, OPK_MOVE_FILE, OPK_LITERAL, OPK_OPTION
  } op_kind_t;

  typedef struct packed {
    op_kind_t            kind;
    logic                dest_file;
    logic [FADDR_W-1:0]  faddr;
    logic [DATA_W-1:0]   literal;
  } dec_t;
endpackage
`default_nettype wire

// *** exec_decode.sv ***
// Purpose: split an instruction word into kind, destination and operands
// Assumes: word is stable while instr_valid_in is high
// Notes:   unknown words decode as no-operation
`default_nettype none
module exec_decode
  import exec_pkg::*;
(
  input  wire logic [11:0] instr_in,
  output var  dec_t        dec_out
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // field extraction and opcode match
  always_comb begin
    dec_out.dest_file = instr_in[DEST_BIT];
    dec_out.faddr     = instr_in[FADDR_LSB +: FADDR_W];
    dec_out.literal   = instr_in[7:0];
    dec_out.kind      = OPK_NONE;
    if (instr_in == OP_NOP) begin
      dec_out.kind = OPK_NONE;
    end else if (instr_in == OP_OPTION) begin
      dec_out.kind = OPK_OPTION;
    end else if (instr_in[11:6] == OP_W_TO_FILE_HI && instr_in[DEST_BIT]) begin
      dec_out.kind = OPK_W_TO_FILE;
    end else if (instr_in[11:6] == OP_IOR_HI) begin
      dec_out.kind = OPK_OR;
    end else if (instr_in[11:6] == OP_MOVE_FILE_HI) begin
      dec_out.kind = OPK_MOVE_FILE;
    end else if (instr_in[11:8] == OP_LITERAL_HI) begin
      dec_out.kind = OPK_LITERAL;
    end
  end
endmodule
`default_nettype wire

// *** exec_datapath.sv ***
// Purpose: execution datapath for or, moves, literal load, nop and option load
// Assumes: one instruction per valid cycle from the same clock domain
// Notes:   file registers are held locally as 32 flip-flop words
// Notes on behaviour
// - or-with-file ORs working and file register and sets zero from the result.
// - or-with-file writes working when the destination bit is 0, the file when 1.
// - move-working-to-file copies working into the file and touches no flag.
// - move-file reads the file and sends it to the selected destination.
// - move-file destination 0 is working, 1 rewrites the same file register.
// - move-file sets zero from the moved value, so a rewrite tests the register.
// - literal load puts the 8-bit immediate in working and touches no flag.
// - option load copies working into the option register, flags untouched.
`default_nettype none
module exec_datapath
  import exec_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              nrst_in,
  input  wire logic              instr_valid_in,
  input  wire logic [11:0]       instr_in,
  output logic [DATA_W-1:0]      w_out,
  output logic [DATA_W-1:0]      option_out,
  output logic                   zero_out,
  output logic                   pc_advance_out,
  output logic [DATA_W-1:0]      file_rd_out
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  dec_t dec;

  exec_decode u_dec (
    .instr_in (instr_in),
    .dec_out  (dec)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] w_q, w_d;
  logic [DATA_W-1:0] opt_q, opt_d;
  logic              z_q, z_d;
  logic              adv_q, adv_d;
  logic [DATA_W-1:0] file_q [NUM_FILES];
  logic [DATA_W-1:0] file_wdata;
  logic              file_we;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] result;

  assign fval = file_q[dec.faddr];

  // next-state for working, option, zero and file write
  always_comb begin
    w_d        = w_q;
    opt_d      = opt_q;
    z_d        = z_q;
    adv_d      = instr_valid_in;
    file_we    = 1'b0;
    file_wdata = w_q;
    result     = fval;
    if (instr_valid_in) begin
      case (dec.kind)
        OPK_OR: begin
          result = w_q | fval;
          z_d    = (result == '0);
          if (dec.dest_file) begin
            file_we    = 1'b1;
            file_wdata = result;
          end else begin
            w_d = result;
          end
        end
        OPK_W_TO_FILE: begin
          file_we    = 1'b1;
          file_wdata = w_q;
        end
        OPK_MOVE_FILE: begin
          result = fval;
          z_d    = (fval == '0);
          if (dec.dest_file) begin
            file_we    = 1'b1;
            file_wdata = fval;
          end else begin
            w_d = fval;
          end
        end
        OPK_LITERAL: w_d = dec.literal;
        OPK_OPTION: opt_d = w_q;
        default: ;
      endcase
    end
  end

  // register scalar state
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      w_q   <= W_RST;
      opt_q <= OPTION_RST;
      z_q   <= 1'b0;
      adv_q <= 1'b0;
    end else begin
      w_q   <= w_d;
      opt_q <= opt_d;
      z_q   <= z_d;
      adv_q <= adv_d;
    end
  end

  // file register array, one word per location
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILES; gi++) begin : g_file
      logic [DATA_W-1:0] fd;
      always_comb begin
        fd = file_q[gi];
        if (file_we && dec.faddr == FADDR_W'(gi)) begin
          fd = file_wdata;
        end
      end
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          file_q[gi] <= FILE_RST;
        end else begin
          file_q[gi] <= fd;
        end
      end
      // a word changes only under a valid instruction that addresses it
      AST_FILE_KEEP: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !(instr_valid_in && dec.faddr == FADDR_W'(gi)) |=> $stable(file_q[gi]))
        else $error("unaddressed file word changed");
    end
  endgenerate

  // registered read port mirrors the addressed file word
  logic [DATA_W-1:0] rd_q, rd_d;
  always_comb begin
    rd_d = fval;
  end
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_q <= FILE_RST;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign w_out          = w_q;
  assign option_out     = opt_q;
  assign zero_out       = z_q;
  assign pc_advance_out = adv_q;
  assign file_rd_out    = rd_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // or results, both destinations, with the zero flag
  AST_OR_W: assert property (
    instr_valid_in && dec.kind == OPK_OR && !dec.dest_file
    |=> w_q == ($past(w_q) | $past(fval)) && z_q == (w_q == '0))
    else $error("or to working wrong");
  AST_OR_F: assert property (
    instr_valid_in && dec.kind == OPK_OR && dec.dest_file
    |=> w_q == $past(w_q) && file_q[$past(dec.faddr)] == ($past(w_q) | $past(fval))
        && z_q == (($past(w_q) | $past(fval)) == '0))
    else $error("or to file wrong");

  // copy of working into a file word, flags and working untouched
  AST_W_TO_FILE: assert property (
    instr_valid_in && dec.kind == OPK_W_TO_FILE
    |=> file_q[$past(dec.faddr)] == $past(w_q) && $stable(z_q))
    else $error("move working to file wrong");
  AST_W_TO_FILE_KEEP: assert property (
    instr_valid_in && dec.kind == OPK_W_TO_FILE |=> $stable(w_q) && $stable(opt_q))
    else $error("move working to file disturbed working");

  // move-file to either destination and its zero test
  AST_MOVE_FILE_W: assert property (
    instr_valid_in && dec.kind == OPK_MOVE_FILE && !dec.dest_file
    |=> w_q == $past(fval))
    else $error("move file to working wrong");
  AST_MOVE_FILE_F: assert property (
    instr_valid_in && dec.kind == OPK_MOVE_FILE && dec.dest_file
    |=> $stable(w_q) && file_q[$past(dec.faddr)] == $past(fval))
    else $error("move file rewrite wrong");
  AST_MOVE_FILE_Z: assert property (
    instr_valid_in && dec.kind == OPK_MOVE_FILE |=> z_q == ($past(fval) == '0))
    else $error("move file zero wrong");

  // literal and option loads leave the flags alone
  AST_LITERAL: assert property (
    instr_valid_in && dec.kind == OPK_LITERAL
    |=> w_q == $past(dec.literal) && $stable(z_q))
    else $error("literal load wrong");
  AST_OPTION: assert property (
    instr_valid_in && dec.kind == OPK_OPTION
    |=> opt_q == $past(w_q) && $stable(z_q) && $stable(w_q))
    else $error("option load wrong");
  AST_OPT_KEEP: assert property (
    !(instr_valid_in && dec.kind == OPK_OPTION) |=> $stable(opt_q))
    else $error("option changed by another instruction");

  // idle cycles and nop
  AST_NOP: assert property (
    instr_valid_in && dec.kind == OPK_NONE
    |=> $stable(w_q) && $stable(z_q) && $stable(opt_q) && pc_advance_out)
    else $error("nop changed state");
  AST_IDLE: assert property (
    !instr_valid_in |=> $stable(w_q) && $stable(z_q) && !pc_advance_out)
    else $error("state changed without instruction");

  // observation port shows the addressed word as it stood before the edge
  AST_RD_MIRROR: assert property (
    1'b1 |=> file_rd_out == $past(fval))
    else $error("file read port wrong");

  // main scenarios reached
  COV_OR_F: cover property (instr_valid_in && dec.kind == OPK_OR && dec.dest_file);
  COV_MOVE_FILE_Z: cover property (instr_valid_in && dec.kind == OPK_MOVE_FILE ##1 z_q);
  COV_LITERAL_OPT: cover property (instr_valid_in && dec.kind == OPK_LITERAL
                                   ##1 instr_valid_in && dec.kind == OPK_OPTION);
  COV_W_TO_FILE: cover property (instr_valid_in && dec.kind == OPK_W_TO_FILE);
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the move/or execution datapath
// Assumes: inputs change at the falling edge, outputs settle 1 ns after rising
// Notes:   a bench model tracks working, option, zero and the 32 file words
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic              core_clk_in;
  logic              nrst_in;
  logic              instr_valid_in;
  logic [11:0]       instr_in;
  logic [DATA_W-1:0] w_out;
  logic [DATA_W-1:0] option_out;
  logic [DATA_W-1:0] file_rd_out;
  logic              zero_out;
  logic              pc_advance_out;
  int                error_cnt;
  int                checked;
  logic [15:0]       seed;
  logic [7:0]        m_w;
  logic [7:0]        m_opt;
  logic [7:0]        m_rd;
  logic              m_z;
  logic              m_pc;
  logic [7:0]        m_f [NUM_FILES];

  exec_datapath dut (
    .core_clk_in    (core_clk_in),
    .nrst_in        (nrst_in),
    .instr_valid_in (instr_valid_in),
    .instr_in       (instr_in),
    .w_out          (w_out),
    .option_out     (option_out),
    .zero_out       (zero_out),
    .pc_advance_out (pc_advance_out),
    .file_rd_out    (file_rd_out)
  );

  // 50 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask

  task automatic check_all;
    chk8("w", m_w, w_out);
    chk8("option", m_opt, option_out);
    chk8("file_rd", m_rd, file_rd_out);
    chk1("zero", m_z, zero_out);
    chk1("pc_advance", m_pc, pc_advance_out);
  endtask

  // expected or/move-file result from the instruction and model words
  function automatic logic [7:0] exp_result(input logic [11:0] i,
                                            input logic [7:0]  w,
                                            input logic [7:0]  f);
    return (i[11:6] == OP_IOR_HI) ? (w | f) : f;
  endfunction

  // one instruction, then model update and compare
  task automatic step(input logic v, input logic [11:0] i);
    logic [4:0] a;
    logic [7:0] r;
    @(negedge core_clk_in);
    instr_valid_in = v;
    instr_in = i;
    @(posedge core_clk_in);
    #1;
    a = i[4:0];
    m_rd = m_f[a];
    m_pc = v;
    if (v) begin
      if (i == OP_OPTION) m_opt = m_w;
      else if (i[11:6] == OP_W_TO_FILE_HI && i[5]) m_f[a] = m_w;
      else if (i[11:6] == OP_IOR_HI || i[11:6] == OP_MOVE_FILE_HI) begin
        r = exp_result(i, m_w, m_f[a]);
        m_z = (r == 8'h00);
        if (i[DEST_BIT]) m_f[a] = r;
        else m_w = r;
      end else if (i[11:8] == OP_LITERAL_HI) m_w = i[7:0];
    end
    check_all();
  endtask

  task automatic do_reset;
    @(negedge core_clk_in);
    nrst_in = 1'b0;
    // no stale instruction may run at the edge after release
    instr_valid_in = 1'b0;
    repeat (5) @(negedge core_clk_in);
    m_w = W_RST;
    m_opt = OPTION_RST;
    m_z = 1'b0;
    m_pc = 1'b0;
    m_rd = FILE_RST;
    foreach (m_f[k]) m_f[k] = FILE_RST;
    check_all();
    nrst_in = 1'b1;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = 12'h000;
    error_cnt = 0;
    checked = 0;
    seed = 16'h001F;
    do_reset();
    step(1'b1, 12'hCA5);
    step(1'b1, 12'h023);
    step(1'b1, 12'h203);
    step(1'b1, 12'h002);
    step(1'b1, 12'hC00);
    step(1'b1, 12'h03F);
    step(1'b1, 12'h11F);
    step(1'b1, 12'hC80);
    step(1'b1, 12'h13F);
    step(1'b1, 12'h23E);
    step(1'b1, 12'h23F);
    step(1'b0, 12'hC55);
    step(1'b1, 12'h000);
    step(1'b1, 12'hFFF);
    // random mix, every kind of instruction
    repeat (600) begin
      seed = lfsr(seed);
      case (seed[2:0])
        3'd0: step(seed[3] | seed[4], OP_NOP);
        3'd1: step(seed[3] | seed[4], OP_OPTION);
        3'd2: step(seed[3] | seed[4], {OP_W_TO_FILE_HI, 1'b1, seed[9:5]});
        3'd3: step(seed[3] | seed[4], {OP_IOR_HI, seed[10], seed[9:5]});
        3'd4: step(seed[3] | seed[4], {OP_MOVE_FILE_HI, seed[10], seed[9:5]});
        3'd5: step(seed[3] | seed[4], {OP_LITERAL_HI, seed[15:8]});
        3'd6: step(seed[3] | seed[4], {OP_LITERAL_HI, 8'h00});
        default: step(seed[3] | seed[4], {4'hF, seed[15:8]});
      endcase
    end
    // reset in mid-run clears the file words too
    do_reset();
    step(1'b1, 12'h205);
    step(1'b1, 12'h002);
    finish_test();
  end

  // hang guard, a few times the expected run length
  initial begin
    #(3000 * 20);
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
